// ### logic/cmp_window.sv
// Window comparator of one reading against a high and a low threshold.
// Assumes reading and thresholds share one encoding, signed or unsigned.
`timescale 1ns/1ns
module cmp_window #(
    parameter int         W          = 16,
    parameter logic       SIGNED_CMP = 1'b0
) (
    // Reading and thresholds
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] thr_hi,
    input  wire logic [W-1:0] thr_lo,
    // Results
    output logic              above,
    output logic              below
);

    // Flipping the sign bit turns two's complement order into plain order
    localparam logic [W-1:0] BIAS = SIGNED_CMP ? {1'b1, {(W-1){1'b0}}} : '0;

    wire [W-1:0] v_b  = value ^ BIAS;
    wire [W-1:0] hi_b = thr_hi ^ BIAS;
    wire [W-1:0] lo_b = thr_lo ^ BIAS;

    // Strict compares: equal to a threshold raises nothing
    assign above = v_b > hi_b;
    assign below = v_b < lo_b;

endmodule : cmp_window

// ### logic/diag_alarm_warning_flags.sv
// Diagnostic alarm and warning flags with threshold registers on APB.
// Assumes readings and the update strobe come from logic on pclk.
//
// Operation
// - Temperature above high alarm threshold sets primary alarm bit 7.
// - Temperature below low alarm threshold sets primary alarm bit 6.
// - Supply voltage above high alarm threshold sets primary alarm bit 5.
// - Supply voltage below low alarm threshold sets primary alarm bit 4.
// - Modulation margin below low alarm threshold sets secondary alarm bit 5.
// - Temperature above high warning threshold sets primary warning bit 7.
// - Temperature below low warning threshold sets primary warning bit 6.
// - Supply voltage above high warning threshold sets primary warning bit 5.
// - Supply voltage below low warning threshold sets primary warning bit 4.
// - Modulation margin below low warning threshold sets secondary warning bit 5.
// - Unused flag byte bits always read as zero.
// - Writes to flag bytes are acknowledged but change nothing.
// - Temperature compares as 16-bit signed values.
// - Supply voltage compares as 16-bit unsigned values.
// - Modulation margin compares as 8-bit signed values.
// - Flag bytes sit at indices 112, 113, 116 and 117.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
module diag_alarm_warning_flags (
    // Clock, reset and enable
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   ce,
    // APB slave
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [diag_flags_pkg::ADDR_W-1:0]      paddr,
    input  wire logic [diag_flags_pkg::DATA_W-1:0]      pwdata,
    output logic      [diag_flags_pkg::DATA_W-1:0]      prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    // Measurement front end
    input  wire logic [diag_flags_pkg::TEMP_W-1:0]      temp_reading,
    input  wire logic [diag_flags_pkg::VCC_W-1:0]       vcc_reading,
    input  wire logic [diag_flags_pkg::MARGIN_W-1:0]    margin_reading,
    input  wire logic                                   meas_valid,
    // Interrupt
    output logic                                        irq
);

    import diag_flags_pkg::*;

    // Places one flag into its byte position
    function automatic logic [7:0] put(input logic b, input int pos);
        put = 8'(b) << pos;
    endfunction : put

    logic [15:0]          thr16 [THR16_N];
    logic [MARGIN_W-1:0]  thr_mrg_alm;
    logic [MARGIN_W-1:0]  thr_mrg_wrn;
    logic [TEMP_W-1:0]    temp_now;
    logic [VCC_W-1:0]     vcc_now;
    logic [FLAG_N-1:0]    flags;
    logic [FLAG_N-1:0]    status;
    logic [FLAG_N-1:0]    mask;
    logic [DATA_W-1:0]    rd_word;

    // Address decode
    wire [IDX_W-1:0]   word    = paddr[IDX_W+1:2];
    wire               addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_W+2] == '0);
    wire [THR16_N-1:0] sel_thr16;
    wire               sel_mrg_alm  = addr_ok && (word == IDX_MRG_ALM);
    wire               sel_mrg_wrn  = addr_ok && (word == IDX_MRG_WRN);
    wire               sel_temp_now = addr_ok && (word == IDX_TEMP_NOW);
    wire               sel_vcc_now  = addr_ok && (word == IDX_VCC_NOW);
    wire               sel_ap       = addr_ok && (word == IDX_ALARM_PRIMARY);
    wire               sel_as       = addr_ok && (word == IDX_ALARM_SECOND);
    wire               sel_wp       = addr_ok && (word == IDX_WARN_PRIMARY);
    wire               sel_ws       = addr_ok && (word == IDX_WARN_SECOND);
    wire               sel_status   = addr_ok && (word == IDX_EVT_STATUS);
    wire               sel_mask     = addr_ok && (word == IDX_EVT_MASK);
    wire               sel_flag     = sel_ap || sel_as || sel_wp || sel_ws;

    for (genvar i = 0; i < THR16_N; i++) begin : g_dec
        assign sel_thr16[i] = addr_ok && (word == IDX_THR16[i]);
    end

    wire hit = (|sel_thr16) || sel_mrg_alm || sel_mrg_wrn || sel_temp_now
             || sel_vcc_now || sel_flag || sel_status || sel_mask;

    // Access phase before the answer; writes land at the completing edge
    wire access = psel && penable && !pready;
    wire wr     = ce && psel && penable && pready && pwrite;

    // Sixteen-bit threshold registers
    for (genvar i = 0; i < THR16_N; i++) begin : g_thr
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                thr16[i] <= THR16_RST[i];
            end else if (wr && sel_thr16[i]) begin
                thr16[i] <= pwdata[15:0];
            end
        end
    end

    // Margin threshold registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_mrg_alm <= MRG_ALM_RST;
            thr_mrg_wrn <= MRG_WRN_RST;
        end else begin
            if (wr && sel_mrg_alm) begin
                thr_mrg_alm <= pwdata[MARGIN_W-1:0];
            end
            if (wr && sel_mrg_wrn) begin
                thr_mrg_wrn <= pwdata[MARGIN_W-1:0];
            end
        end
    end

    // Comparator results
    wire c_temp_hi_alm;
    wire c_temp_lo_alm;
    wire c_temp_hi_wrn;
    wire c_temp_lo_wrn;
    wire c_vcc_hi_alm;
    wire c_vcc_lo_alm;
    wire c_vcc_hi_wrn;
    wire c_vcc_lo_wrn;
    wire c_mrg_lo_alm;
    wire c_mrg_lo_wrn;

    // Temperature, signed
    cmp_window #(.W(TEMP_W), .SIGNED_CMP(1'b1)) u_temp_alm (
        .value  (temp_reading),
        .thr_hi (thr16[T_TEMP_HI_ALM]),
        .thr_lo (thr16[T_TEMP_LO_ALM]),
        .above  (c_temp_hi_alm),
        .below  (c_temp_lo_alm)
    );
    cmp_window #(.W(TEMP_W), .SIGNED_CMP(1'b1)) u_temp_wrn (
        .value  (temp_reading),
        .thr_hi (thr16[T_TEMP_HI_WRN]),
        .thr_lo (thr16[T_TEMP_LO_WRN]),
        .above  (c_temp_hi_wrn),
        .below  (c_temp_lo_wrn)
    );

    // Supply voltage, unsigned
    cmp_window #(.W(VCC_W), .SIGNED_CMP(1'b0)) u_vcc_alm (
        .value  (vcc_reading),
        .thr_hi (thr16[T_VCC_HI_ALM]),
        .thr_lo (thr16[T_VCC_LO_ALM]),
        .above  (c_vcc_hi_alm),
        .below  (c_vcc_lo_alm)
    );
    cmp_window #(.W(VCC_W), .SIGNED_CMP(1'b0)) u_vcc_wrn (
        .value  (vcc_reading),
        .thr_hi (thr16[T_VCC_HI_WRN]),
        .thr_lo (thr16[T_VCC_LO_WRN]),
        .above  (c_vcc_hi_wrn),
        .below  (c_vcc_lo_wrn)
    );

    // Modulation margin, signed, low side only
    cmp_window #(.W(MARGIN_W), .SIGNED_CMP(1'b1)) u_mrg_alm (
        .value  (margin_reading),
        .thr_hi (thr_mrg_alm),
        .thr_lo (thr_mrg_alm),
        .above  (),
        .below  (c_mrg_lo_alm)
    );
    cmp_window #(.W(MARGIN_W), .SIGNED_CMP(1'b1)) u_mrg_wrn (
        .value  (margin_reading),
        .thr_hi (thr_mrg_wrn),
        .thr_lo (thr_mrg_wrn),
        .above  (),
        .below  (c_mrg_lo_wrn)
    );

    // Flag vector for the next update
    wire [FLAG_N-1:0] next_flags;
    assign next_flags[FA_THI] = c_temp_hi_alm;
    assign next_flags[FA_TLO] = c_temp_lo_alm;
    assign next_flags[FA_VHI] = c_vcc_hi_alm;
    assign next_flags[FA_VLO] = c_vcc_lo_alm;
    assign next_flags[FA_MLO] = c_mrg_lo_alm;
    assign next_flags[FW_THI] = c_temp_hi_wrn;
    assign next_flags[FW_TLO] = c_temp_lo_wrn;
    assign next_flags[FW_VHI] = c_vcc_hi_wrn;
    assign next_flags[FW_VLO] = c_vcc_lo_wrn;
    assign next_flags[FW_MLO] = c_mrg_lo_wrn;

    // Update strobe, newly raised flags, and write-one-to-clear
    wire              upd         = ce && meas_valid;
    wire [FLAG_N-1:0] raise       = upd ? (next_flags & ~flags) : '0;
    wire [FLAG_N-1:0] w1c         = (wr && sel_status) ? pwdata[FLAG_N-1:0] : '0;
    wire [FLAG_N-1:0] next_status = (status & ~w1c) | raise;  // Set wins over clear

    // Flags and latest readings, replaced on every update only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags    <= FLAGS_RST;
            temp_now <= READ_RST;
            vcc_now  <= READ_RST;
        end else if (upd) begin
            flags    <= next_flags;
            temp_now <= temp_reading;
            vcc_now  <= vcc_reading;
        end
    end

    // Event status, mask and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= STATUS_RST;
            mask   <= MASK_RST;
            irq    <= 1'b0;
        end else if (ce) begin
            status <= next_status;
            irq    <= |(status & mask);
            if (wr && sel_mask) begin
                mask <= pwdata[FLAG_N-1:0];
            end
        end
    end

    // Flag bytes with unused bits fixed at zero
    wire [7:0] byte_ap = put(flags[FA_THI], BIT_TEMP_HIGH) | put(flags[FA_TLO], BIT_TEMP_LOW)
                       | put(flags[FA_VHI], BIT_VCC_HIGH) | put(flags[FA_VLO], BIT_VCC_LOW);
    wire [7:0] byte_as = put(flags[FA_MLO], BIT_MARGIN_LOW);
    wire [7:0] byte_wp = put(flags[FW_THI], BIT_TEMP_HIGH) | put(flags[FW_TLO], BIT_TEMP_LOW)
                       | put(flags[FW_VHI], BIT_VCC_HIGH) | put(flags[FW_VLO], BIT_VCC_LOW);
    wire [7:0] byte_ws = put(flags[FW_MLO], BIT_MARGIN_LOW);

    // Read data selection
    always_comb begin
        rd_word = WORD_ZERO;
        for (int i = 0; i < THR16_N; i++) begin
            if (sel_thr16[i]) begin
                rd_word = {16'h0000, thr16[i]};
            end
        end
        if (sel_mrg_alm) rd_word = {24'h00_0000, thr_mrg_alm};
        if (sel_mrg_wrn) rd_word = {24'h00_0000, thr_mrg_wrn};
        if (sel_temp_now) rd_word = {16'h0000, temp_now};
        if (sel_vcc_now) rd_word = {16'h0000, vcc_now};
        if (sel_ap) rd_word = {24'h00_0000, byte_ap};
        if (sel_as) rd_word = {24'h00_0000, byte_as};
        if (sel_wp) rd_word = {24'h00_0000, byte_wp};
        if (sel_ws) rd_word = {24'h00_0000, byte_ws};
        if (sel_status) rd_word = {22'h00_0000, status};
        if (sel_mask) rd_word = {22'h00_0000, mask};
    end

    // APB answer one cycle into the access phase; flag writes fall through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= WORD_ZERO;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= access;
            if (access) begin
                prdata  <= pwrite ? WORD_ZERO : rd_word;
                pslverr <= !hit;
            end
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TEMP_HI_ALM: assert property (upd |=> byte_ap[BIT_TEMP_HIGH]
        == $past($signed(temp_reading) > $signed(thr16[T_TEMP_HI_ALM])))
        else $error("temperature high alarm wrong");
    AST_TEMP_LO_ALM: assert property (upd |=> byte_ap[BIT_TEMP_LOW]
        == $past($signed(temp_reading) < $signed(thr16[T_TEMP_LO_ALM])))
        else $error("temperature low alarm wrong");
    AST_VCC_HI_ALM: assert property (upd |=> byte_ap[BIT_VCC_HIGH]
        == $past(vcc_reading > thr16[T_VCC_HI_ALM]))
        else $error("supply high alarm wrong");
    AST_VCC_LO_ALM: assert property (upd |=> byte_ap[BIT_VCC_LOW]
        == $past(vcc_reading < thr16[T_VCC_LO_ALM]))
        else $error("supply low alarm wrong");
    AST_MRG_LO_ALM: assert property (upd |=> byte_as[BIT_MARGIN_LOW]
        == $past($signed(margin_reading) < $signed(thr_mrg_alm)))
        else $error("margin low alarm wrong");
    AST_TEMP_HI_WRN: assert property (upd |=> byte_wp[BIT_TEMP_HIGH]
        == $past($signed(temp_reading) > $signed(thr16[T_TEMP_HI_WRN])))
        else $error("temperature high warning wrong");
    AST_TEMP_LO_WRN: assert property (upd |=> byte_wp[BIT_TEMP_LOW]
        == $past($signed(temp_reading) < $signed(thr16[T_TEMP_LO_WRN])))
        else $error("temperature low warning wrong");
    AST_VCC_HI_WRN: assert property (upd |=> byte_wp[BIT_VCC_HIGH]
        == $past(vcc_reading > thr16[T_VCC_HI_WRN]))
        else $error("supply high warning wrong");
    AST_VCC_LO_WRN: assert property (upd |=> byte_wp[BIT_VCC_LOW]
        == $past(vcc_reading < thr16[T_VCC_LO_WRN]))
        else $error("supply low warning wrong");
    AST_MRG_LO_WRN: assert property (upd |=> byte_ws[BIT_MARGIN_LOW]
        == $past($signed(margin_reading) < $signed(thr_mrg_wrn)))
        else $error("margin low warning wrong");
    AST_UNUSED_ZERO: assert property (psel && penable && pready && !pwrite
        && sel_flag |-> prdata[DATA_W-1:8] == '0
        && ((sel_ap || sel_wp) ? prdata[3:0] == '0 : (prdata[7:6] == '0 && prdata[4:0] == '0)))
        else $error("unused flag bits not zero");
    AST_FLAG_WRITE_IGNORED: assert property (wr && sel_flag && !meas_valid
        |=> $stable(flags) && !pslverr)
        else $error("flag write had an effect");
    AST_ALARM_MAP: assert property (psel && penable && pready && !pwrite
        && sel_ap |-> prdata == {24'h00_0000, $past(byte_ap)})
        else $error("primary alarm byte misplaced");
    AST_FLAG_HOLD: assert property (!upd |=> $stable(flags))
        else $error("flags changed without update");
    AST_ANSWER: assert property (ce && access |=> pready ##1 !pready)
        else $error("APB answer timing wrong");
    AST_IRQ: assert property (ce && (status & mask) != '0 |=> irq)
        else $error("interrupt not raised");
    AST_IRQ_LOW: assert property (ce && (status & mask) == '0 |=> !irq)
        else $error("interrupt raised without cause");

    COV_ALARM: cover property (upd ##1 flags[FA_THI]);
    COV_CLEAR: cover property (flags[FA_VLO] ##1 upd ##1 !flags[FA_VLO]);
    COV_IRQ: cover property (irq);
    COV_FLAG_WRITE: cover property (wr && sel_flag);

endmodule : diag_alarm_warning_flags

// ### logic/diag_flags_pkg.sv
// Constants shared by the diagnostic alarm and warning flag block.
// Assumes a 32-bit APB register bus; each register holds one aligned word.
package diag_flags_pkg;

    // Bus and data widths
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int IDX_W    = 7;
    localparam int TEMP_W   = 16;
    localparam int VCC_W    = 16;
    localparam int MARGIN_W = 8;
    localparam int THR16_N  = 8;
    localparam int FLAG_N   = 10;

    // Slots of the 16-bit threshold array
    localparam int T_TEMP_HI_ALM = 0;
    localparam int T_TEMP_LO_ALM = 1;
    localparam int T_TEMP_HI_WRN = 2;
    localparam int T_TEMP_LO_WRN = 3;
    localparam int T_VCC_HI_ALM  = 4;
    localparam int T_VCC_LO_ALM  = 5;
    localparam int T_VCC_HI_WRN  = 6;
    localparam int T_VCC_LO_WRN  = 7;

    // Register word indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_THR16 [THR16_N] = '{
        7'h00, 7'h02, 7'h04, 7'h06, 7'h08, 7'h0A, 7'h0C, 7'h0E};
    localparam logic [IDX_W-1:0] IDX_MRG_ALM       = 7'h28;
    localparam logic [IDX_W-1:0] IDX_MRG_WRN       = 7'h29;
    localparam logic [IDX_W-1:0] IDX_TEMP_NOW      = 7'h60;
    localparam logic [IDX_W-1:0] IDX_VCC_NOW       = 7'h62;
    localparam logic [IDX_W-1:0] IDX_ALARM_PRIMARY = 7'h70;
    localparam logic [IDX_W-1:0] IDX_ALARM_SECOND  = 7'h71;
    localparam logic [IDX_W-1:0] IDX_WARN_PRIMARY  = 7'h74;
    localparam logic [IDX_W-1:0] IDX_WARN_SECOND   = 7'h75;
    localparam logic [IDX_W-1:0] IDX_EVT_STATUS    = 7'h78;
    localparam logic [IDX_W-1:0] IDX_EVT_MASK      = 7'h79;

    // Threshold values after reset
    localparam logic [15:0] THR16_RST [THR16_N] = '{
        16'h7300, 16'hD800, 16'h6900, 16'hE700,
        16'h9858, 16'h6978, 16'h8DCC, 16'h7404};
    localparam logic [MARGIN_W-1:0] MRG_ALM_RST = 8'h08;
    localparam logic [MARGIN_W-1:0] MRG_WRN_RST = 8'h12;

    // Bit positions inside the flag bytes
    localparam int BIT_TEMP_HIGH  = 7;
    localparam int BIT_TEMP_LOW   = 6;
    localparam int BIT_VCC_HIGH   = 5;
    localparam int BIT_VCC_LOW    = 4;
    localparam int BIT_MARGIN_LOW = 5;

    // Positions in the flag, event status and mask vectors
    localparam int FA_THI = 0;
    localparam int FA_TLO = 1;
    localparam int FA_VHI = 2;
    localparam int FA_VLO = 3;
    localparam int FA_MLO = 4;
    localparam int FW_THI = 5;
    localparam int FW_TLO = 6;
    localparam int FW_VHI = 7;
    localparam int FW_VLO = 8;
    localparam int FW_MLO = 9;

    // Values after reset
    localparam logic [FLAG_N-1:0] FLAGS_RST  = 10'h000;
    localparam logic [FLAG_N-1:0] STATUS_RST = 10'h000;
    localparam logic [FLAG_N-1:0] MASK_RST   = 10'h000;
    localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;
    localparam logic [TEMP_W-1:0] READ_RST   = 16'h0000;

endpackage : diag_flags_pkg

// ### verif/apb_host_model.sv
// APB host model that reads and writes the flag block's registers.
// Assumes one pclk domain; waits for pready, the bench watchdog ends a hang.
`timescale 1ns/1ns
module apb_host_model (
    // Clock
    input  wire logic                              pclk,
    // APB master side
    output logic                                   psel,
    output logic                                   penable,
    output logic                                   pwrite,
    output logic      [diag_flags_pkg::ADDR_W-1:0] paddr,
    output logic      [diag_flags_pkg::DATA_W-1:0] pwdata,
    input  wire logic [diag_flags_pkg::DATA_W-1:0] prdata,
    input  wire logic                              pready,
    input  wire logic                              pslverr
);
    import diag_flags_pkg::*;

    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = WORD_ZERO;
    end

    // One transfer: setup, then access held until pready at a rising edge
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host_model

// ### verif/tb_diag_alarm_warning_flags.sv
// Self-checking bench for the diagnostic alarm and warning flag block.
// Assumes the host model drives APB; the bench drives readings and ce.
`timescale 1ns/1ns
module tb_diag_alarm_warning_flags;
    import diag_flags_pkg::*;
    logic                pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, meas_valid, irq;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata, d;
    logic                e;
    logic [TEMP_W-1:0]   temp_reading;
    logic [VCC_W-1:0]    vcc_reading;
    logic [MARGIN_W-1:0] margin_reading;
    int                  num_errors = 0;
    int                  checked = 0;

    // Design and host
    diag_alarm_warning_flags dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .temp_reading(temp_reading), .vcc_reading(vcc_reading), .margin_reading(margin_reading),
        .meas_valid(meas_valid), .irq(irq));
    apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [ADDR_W-1:0] addr_of(input logic [IDX_W-1:0] idx);
        return {3'b000, idx, 2'b00};
    endfunction : addr_of

    task automatic rd(input logic [IDX_W-1:0] idx);
        host.xfer(1'b0, addr_of(idx), WORD_ZERO, d, e);
    endtask : rd

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] v);
        host.xfer(1'b1, addr_of(idx), v, d, e);
    endtask : wr

    // One measurement update pulse
    task automatic measure(input logic [15:0] t, input logic [15:0] v, input logic [7:0] m);
        @(posedge pclk);
        temp_reading <= t;
        vcc_reading <= v;
        margin_reading <= m;
        meas_valid <= 1'b1;
        @(posedge pclk);
        meas_valid <= 1'b0;
    endtask : measure

    // Reads all four flag bytes
    task automatic flags(input logic [7:0] a1, input logic [7:0] a2, input logic [7:0] w1, input logic [7:0] w2);
        rd(IDX_ALARM_PRIMARY);
        check(d, {24'h000000, a1});
        rd(IDX_ALARM_SECOND);
        check(d, {24'h000000, a2});
        rd(IDX_WARN_PRIMARY);
        check(d, {24'h000000, w1});
        rd(IDX_WARN_SECOND);
        check(d, {24'h000000, w2});
    endtask : flags

    // Reset values of thresholds except the margin warning one, mask and flags
    task automatic t_reset_values;
        for (int i = 0; i < THR16_N; i++) begin
            rd(IDX_THR16[i]);
            check(d, {16'h0000, THR16_RST[i]});
        end
        rd(IDX_MRG_ALM);
        check(d, {24'h000000, MRG_ALM_RST});
        rd(IDX_EVT_MASK);
        check(d, WORD_ZERO);
        flags(8'h00, 8'h00, 8'h00, 8'h00);
    endtask : t_reset_values

    // Every comparison tripped at least once, several at a boundary; ends with margin equal to its alarm threshold
    task automatic t_compare;
        measure(16'h7301, 16'h80E8, 8'h20); flags(8'h80, 8'h00, 8'h80, 8'h00);
        measure(16'h7300, 16'h80E8, 8'h20); flags(8'h00, 8'h00, 8'h80, 8'h00);
        measure(16'h8000, 16'h80E8, 8'h20); flags(8'h40, 8'h00, 8'h40, 8'h00);
        measure(16'hE6FF, 16'h80E8, 8'h20); flags(8'h00, 8'h00, 8'h40, 8'h00);
        measure(16'h1900, 16'hFFFF, 8'h20); flags(8'h20, 8'h00, 8'h20, 8'h00);
        measure(16'h1900, 16'h8DCD, 8'h20); flags(8'h00, 8'h00, 8'h20, 8'h00);
        measure(16'h1900, 16'h6977, 8'h20); flags(8'h10, 8'h00, 8'h10, 8'h00);
        measure(16'h1900, 16'h7403, 8'h20); flags(8'h00, 8'h00, 8'h10, 8'h00);
        measure(16'h1900, 16'h80E8, 8'hF0); flags(8'h00, 8'h20, 8'h00, 8'h20);
        measure(16'h1900, 16'h80E8, 8'h11); flags(8'h00, 8'h00, 8'h00, 8'h20);
        measure(16'h1900, 16'h80E8, 8'h08); flags(8'h00, 8'h00, 8'h00, 8'h20);
    endtask : t_compare

    // New threshold, read-only flag writes, ce freeze
    task automatic t_writes;
        wr(IDX_THR16[T_TEMP_HI_ALM], 32'h00000100);
        measure(16'h0101, 16'h80E8, 8'h20);
        rd(IDX_TEMP_NOW);
        check(d, 32'h00000101);
        wr(IDX_ALARM_PRIMARY, 32'hFFFFFFFF);
        check({31'h0, e}, 32'h0);
        wr(IDX_ALARM_SECOND, 32'hFFFFFFFF);
        flags(8'h80, 8'h00, 8'h00, 8'h00);
        wr(IDX_THR16[T_TEMP_HI_ALM], 32'h00007300);
        ce <= 1'b0;
        measure(16'h1900, 16'h80E8, 8'h20);
        ce <= 1'b1;
        flags(8'h80, 8'h00, 8'h00, 8'h00);
        measure(16'h1900, 16'h80E8, 8'h20);
        flags(8'h00, 8'h00, 8'h00, 8'h00);
    endtask : t_writes

    // Unmapped and misaligned accesses
    task automatic t_unmapped;
        rd(7'h7F);
        check({31'h0, e}, 32'h1);
        check(d, WORD_ZERO);
        host.xfer(1'b0, 12'h1C1, WORD_ZERO, d, e);
        check({31'h0, e}, 32'h1);
    endtask : t_unmapped

    // Event status, mask and interrupt line
    task automatic t_irq;
        wr(IDX_EVT_STATUS, 32'h000003FF);
        wr(IDX_EVT_MASK, 32'h00000001);
        measure(16'h7301, 16'h80E8, 8'h20);
        rd(IDX_EVT_STATUS);
        check(d, 32'h00000021);
        check({31'h0, irq}, 32'h1);
        wr(IDX_EVT_MASK, 32'h00000000);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        wr(IDX_EVT_MASK, 32'h00000001);
        wr(IDX_EVT_STATUS, 32'h00000021);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        measure(16'h1900, 16'h80E8, 8'h20);
    endtask : t_irq

    task automatic end_of_test;
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        meas_valid = 1'b0;
        temp_reading = 16'h1900;
        vcc_reading = 16'h80E8;
        margin_reading = 8'h20;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_compare();
        t_writes();
        t_unmapped();
        t_irq();
        end_of_test();
    end

    // Watchdog
    initial begin
        #(40 * 20000);
        num_errors++;
        end_of_test();
    end
endmodule : tb_diag_alarm_warning_flags
